// *** logic/cdm_pkg.sv ***
/*
  Package for the clock divider and module-stop block: register byte addresses,
  field positions, reset values and the codes that select ratios and sources.
  Assumes a single 20 MHz system clock and an APB master with 32-bit data.
*/
`default_nettype none
package cdm_pkg;
  // ==========================================================================
  // Register byte addresses
  localparam logic [31:0] CDM_ADDR_FREQ = 32'hfffe0010;
  localparam logic [31:0] CDM_ADDR_STBY = 32'hfffe0408;
  localparam logic [31:0] CDM_ADDR_SEC = 32'hfffe0410;
  localparam logic [31:0] CDM_ADDR_CONV = 32'hfffe0414;

  // ==========================================================================
  // Frequency control field positions, 3 bits each
  localparam int CDM_BUS_LSB = 8;
  localparam int CDM_CPU_LSB = 4;
  localparam int CDM_PER_LSB = 0;
  localparam int CDM_RATIO_W = 3;

  // ==========================================================================
  // Standby control: pin float bit and five module-stop bits at 6..2
  localparam int CDM_FLOAT_BIT = 7;
  localparam int CDM_STOP_LSB = 2;
  localparam int CDM_STOP_NUM = 5;
  // Index into the stop vector, bit position minus CDM_STOP_LSB
  localparam int CDM_IDX_SEC = 4;
  localparam int CDM_IDX_MAIN = 3;
  localparam int CDM_IDX_OD = 2;
  localparam int CDM_IDX_I2C = 1;
  localparam int CDM_IDX_CONV = 0;

  // ==========================================================================
  // Secondary timer and converter clock control fields
  localparam int CDM_SRC_LSB = 6;
  localparam int CDM_DIV_LSB = 0;
  localparam int CDM_SEL_W = 2;

  // ==========================================================================
  // Codes
  localparam logic [2:0] CDM_RATIO_ONE = 3'h0;
  localparam logic [2:0] CDM_RATIO_HALF = 3'h1;
  localparam logic [1:0] CDM_SRC_SYS = 2'h0;
  localparam logic [1:0] CDM_SRC_PLL = 2'h1;
  localparam logic [1:0] CDM_DIV_ONE = 2'h0;
  localparam logic [1:0] CDM_DIV_HALF = 2'h1;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] CDM_FREQ_RST = 16'h0000;
  localparam logic [7:0] CDM_STBY_RST = 8'h7c;
  localparam logic [7:0] CDM_SEC_RST = 8'h00;
  localparam logic [7:0] CDM_CONV_RST = 8'h00;

  // Divider counter width, enough for the largest ratio of 1/8
  localparam int CDM_CNT_W = 3;
endpackage : cdm_pkg
`default_nettype wire

// *** logic/cdm_clock_stop_ctrl.sv ***
/*
  Clock divider and module-stop control: APB register file, clock enable
  generation for bus, CPU and peripheral rates, source-selected dividers for
  the secondary motor timer and the converter, module clock gating and pin
  hold control in software standby.
  Assumes pll_tick and standby_active come from logic on pclk; every derived
  clock is a one-cycle enable pulse on pclk.
*/
// Behaviour
// (RULE1) Bus ratio code 001 gives a bus clock at one half of the source rate.
// (RULE2) CPU ratio code 000 runs the CPU clock undivided.
// (RULE3) Peripheral ratio code 001 gives a peripheral clock at half the source rate.
// (RULE4) Secondary timer source code 01 selects the PLL output as its source.
// (RULE5) Secondary timer divider code 01 divides the chosen source by two.
// (RULE6) Converter source code 01 selects the PLL output as its source.
// (RULE7) Converter divider code 01 divides the chosen source by two.
// (RULE8) With the pin float bit at 0, pins hold their state in software standby.
// (RULE9) A set stop bit for the secondary motor timer stops its clock.
// (RULE10) A clear stop bit for the primary timer keeps its clock running.
// (RULE11) Set stop bits for output disable, I2C or converter zero halt their clocks.
// (RULE12) Frequency control holds bus ratio at 10:8, CPU at 6:4, peripheral at 2:0.
// (RULE13) Standby control holds pin float at bit 7 and stop bits at 6 down to 2.
`timescale 1ns/100ps
`default_nettype none
module cdm_clock_stop_ctrl
  import cdm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pll_tick,
  input wire logic standby_active,
  output logic bus_clk_en,
  output logic cpu_clk_en,
  output logic per_clk_en,
  output logic sec_timer_clk_en,
  output logic main_timer_clk_en,
  output logic output_disable_clk_en,
  output logic i2c_clk_en,
  output logic converter_zero_clk_en,
  output logic pin_hold,
  output logic pin_float
);

  // ==========================================================================
  // Register fields
  logic [2:0] bus_ratio_field;
  logic [2:0] cpu_ratio_field;
  logic [2:0] periph_ratio_field;
  logic standby_pin_float;
  logic [CDM_STOP_NUM-1:0] stop_bits;
  logic [1:0] sec_timer_source_sel;
  logic [1:0] sec_timer_divider;
  logic [1:0] converter_source_sel;
  logic [1:0] converter_divider;

  // Named views of the stop bits
  logic stop_sec_timer;
  logic stop_main_timer;
  logic stop_output_disable;
  logic stop_i2c_module;
  logic stop_converter_zero;
  assign stop_sec_timer = stop_bits[CDM_IDX_SEC];
  assign stop_main_timer = stop_bits[CDM_IDX_MAIN];
  assign stop_output_disable = stop_bits[CDM_IDX_OD];
  assign stop_i2c_module = stop_bits[CDM_IDX_I2C];
  assign stop_converter_zero = stop_bits[CDM_IDX_CONV];

  // ==========================================================================
  // APB decode
  logic hit_freq;
  logic hit_stby;
  logic hit_sec;
  logic hit_conv;
  logic mapped;
  logic setup_phase;
  logic wr_take;
  logic [31:0] rd_word;

  assign hit_freq = (paddr == CDM_ADDR_FREQ);
  assign hit_stby = (paddr == CDM_ADDR_STBY);
  assign hit_sec = (paddr == CDM_ADDR_SEC);
  assign hit_conv = (paddr == CDM_ADDR_CONV);
  assign mapped = hit_freq | hit_stby | hit_sec | hit_conv;
  assign setup_phase = psel & ~penable;
  // A write lands only at the completing edge of the access phase
  assign wr_take = psel & penable & pready & pwrite & mapped;

  // Read data assembly, reserved bits read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_freq) begin
      rd_word[CDM_BUS_LSB +: CDM_RATIO_W] = bus_ratio_field; // RULE12
      rd_word[CDM_CPU_LSB +: CDM_RATIO_W] = cpu_ratio_field;
      rd_word[CDM_PER_LSB +: CDM_RATIO_W] = periph_ratio_field;
    end else if (hit_stby) begin
      rd_word[CDM_FLOAT_BIT] = standby_pin_float; // RULE13
      rd_word[CDM_STOP_LSB +: CDM_STOP_NUM] = stop_bits;
    end else if (hit_sec) begin
      rd_word[CDM_SRC_LSB +: CDM_SEL_W] = sec_timer_source_sel;
      rd_word[CDM_DIV_LSB +: CDM_SEL_W] = sec_timer_divider;
    end else if (hit_conv) begin
      rd_word[CDM_SRC_LSB +: CDM_SEL_W] = converter_source_sel;
      rd_word[CDM_DIV_LSB +: CDM_SEL_W] = converter_divider;
    end
  end

  // Answer one cycle after setup: no wait states, all from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase & ~mapped;
      if (setup_phase) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // Frequency control register, two byte lanes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_ratio_field <= CDM_FREQ_RST[CDM_BUS_LSB +: CDM_RATIO_W];
      cpu_ratio_field <= CDM_FREQ_RST[CDM_CPU_LSB +: CDM_RATIO_W];
      periph_ratio_field <= CDM_FREQ_RST[CDM_PER_LSB +: CDM_RATIO_W];
    end else if (wr_take && hit_freq) begin
      if (pstrb[1]) begin
        bus_ratio_field <= pwdata[CDM_BUS_LSB +: CDM_RATIO_W]; // RULE12
      end
      if (pstrb[0]) begin
        cpu_ratio_field <= pwdata[CDM_CPU_LSB +: CDM_RATIO_W];
        periph_ratio_field <= pwdata[CDM_PER_LSB +: CDM_RATIO_W];
      end
    end
  end

  // Standby control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_pin_float <= CDM_STBY_RST[CDM_FLOAT_BIT];
      stop_bits <= CDM_STBY_RST[CDM_STOP_LSB +: CDM_STOP_NUM];
    end else if (wr_take && hit_stby && pstrb[0]) begin
      standby_pin_float <= pwdata[CDM_FLOAT_BIT]; // RULE13
      stop_bits <= pwdata[CDM_STOP_LSB +: CDM_STOP_NUM];
    end
  end

  // Secondary timer and converter clock control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_timer_source_sel <= CDM_SEC_RST[CDM_SRC_LSB +: CDM_SEL_W];
      sec_timer_divider <= CDM_SEC_RST[CDM_DIV_LSB +: CDM_SEL_W];
      converter_source_sel <= CDM_CONV_RST[CDM_SRC_LSB +: CDM_SEL_W];
      converter_divider <= CDM_CONV_RST[CDM_DIV_LSB +: CDM_SEL_W];
    end else if (wr_take && pstrb[0]) begin
      if (hit_sec) begin
        sec_timer_source_sel <= pwdata[CDM_SRC_LSB +: CDM_SEL_W];
        sec_timer_divider <= pwdata[CDM_DIV_LSB +: CDM_SEL_W];
      end
      if (hit_conv) begin
        converter_source_sel <= pwdata[CDM_SRC_LSB +: CDM_SEL_W];
        converter_divider <= pwdata[CDM_DIV_LSB +: CDM_SEL_W];
      end
    end
  end

  // ==========================================================================
  // Divider helpers
  // Ratio code n (0..3) divides by 2**n; codes 1xx fall back to undivided
  function automatic logic [1:0] ratio_shift(input logic [2:0] code);
    ratio_shift = code[2] ? 2'h0 : code[1:0];
  endfunction : ratio_shift

  // Fires when the low shift bits of the counter are all ones
  function automatic logic div_hit(input logic [CDM_CNT_W-1:0] cnt, input logic [1:0] sh);
    logic [CDM_CNT_W-1:0] mask;
    mask = CDM_CNT_W'((4'h1 << sh) - 4'h1);
    div_hit = ((cnt & mask) == mask);
  endfunction : div_hit

  // ==========================================================================
  // Bus, CPU and peripheral rates from one shared counter
  // Sharing one counter keeps the three enables phase aligned to each other
  logic [CDM_CNT_W-1:0] sys_cnt;
  logic [2:0] ratio_code [3];
  logic [2:0] next_ratio_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_cnt <= '0;
    end else begin
      sys_cnt <= sys_cnt + CDM_CNT_W'(1);
    end
  end

  assign ratio_code[0] = bus_ratio_field;
  assign ratio_code[1] = cpu_ratio_field;
  assign ratio_code[2] = periph_ratio_field;

  genvar gr;
  generate
    for (gr = 0; gr < 3; gr++) begin : g_ratio
      assign next_ratio_en[gr] = div_hit(sys_cnt, ratio_shift(ratio_code[gr])); // RULE1 RULE2 RULE3
    end
  endgenerate

  // ==========================================================================
  // Source-selected dividers: index 0 secondary timer, 1 converter
  // Each keeps its own counter since it counts ticks of its selected source, PLL ticks when the PLL is selected
  logic [1:0] src_sel [2];
  logic [1:0] src_div [2];
  logic [1:0] src_tick;
  logic [1:0] next_src_en;
  logic [CDM_CNT_W-1:0] src_cnt [2];

  assign src_sel[0] = sec_timer_source_sel;
  assign src_sel[1] = converter_source_sel;
  assign src_div[0] = sec_timer_divider;
  assign src_div[1] = converter_divider;

  genvar gs;
  generate
    for (gs = 0; gs < 2; gs++) begin : g_src
      // PLL output or, for every other code, the system clock
      assign src_tick[gs] = (src_sel[gs] == CDM_SRC_PLL) ? pll_tick : 1'b1; // RULE4 RULE6
      assign next_src_en[gs] = src_tick[gs] & div_hit(src_cnt[gs], src_div[gs]); // RULE5 RULE7
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          src_cnt[gs] <= '0;
        end else if (src_tick[gs]) begin
          src_cnt[gs] <= src_cnt[gs] + CDM_CNT_W'(1);
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Registered clock enables and module gating
  // Gating the enable rather than the clock avoids glitches on a stop write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_clk_en <= 1'b0;
      cpu_clk_en <= 1'b0;
      per_clk_en <= 1'b0;
      sec_timer_clk_en <= 1'b0;
      main_timer_clk_en <= 1'b0;
      output_disable_clk_en <= 1'b0;
      i2c_clk_en <= 1'b0;
      converter_zero_clk_en <= 1'b0;
    end else begin
      bus_clk_en <= next_ratio_en[0]; // RULE1
      cpu_clk_en <= next_ratio_en[1]; // RULE2
      per_clk_en <= next_ratio_en[2]; // RULE3
      sec_timer_clk_en <= next_src_en[0] & ~stop_sec_timer; // RULE9
      main_timer_clk_en <= next_ratio_en[2] & ~stop_main_timer; // RULE10
      output_disable_clk_en <= next_ratio_en[2] & ~stop_output_disable; // RULE11
      i2c_clk_en <= next_ratio_en[2] & ~stop_i2c_module; // RULE11
      converter_zero_clk_en <= next_src_en[1] & ~stop_converter_zero; // RULE11
    end
  end

  // Pin behaviour in software standby: hold or float
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_hold <= 1'b0;
      pin_float <= 1'b0;
    end else begin
      pin_hold <= standby_active & ~standby_pin_float; // RULE8
      pin_float <= standby_active & standby_pin_float;
    end
  end

  // ==========================================================================
  // Assertions
  AST_BUS_HALF: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    ($past(bus_ratio_field, 2) == CDM_RATIO_HALF && $past(bus_ratio_field) == CDM_RATIO_HALF)
    |-> (bus_clk_en != $past(bus_clk_en)))
    else $error("bus enable does not alternate at half rate");

  AST_CPU_UNDIV: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    ($past(presetn) && $past(cpu_ratio_field) == CDM_RATIO_ONE) |-> cpu_clk_en)
    else $error("cpu enable missing at ratio one");

  AST_PER_HALF: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    ($past(periph_ratio_field, 2) == CDM_RATIO_HALF && $past(periph_ratio_field) == CDM_RATIO_HALF)
    |-> (per_clk_en != $past(per_clk_en)))
    else $error("peripheral enable does not alternate at half rate");

  AST_SEC_PLL: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    ($past(sec_timer_source_sel) == CDM_SRC_PLL && $past(sec_timer_divider) == CDM_DIV_ONE
     && !$past(stop_sec_timer)) |-> (sec_timer_clk_en == $past(pll_tick)))
    else $error("secondary timer enable does not follow the PLL tick");

  AST_SEC_HALF: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    ($past(sec_timer_source_sel, 2) == CDM_SRC_SYS && $past(sec_timer_divider, 2) == CDM_DIV_HALF
     && $past(sec_timer_source_sel) == CDM_SRC_SYS && $past(sec_timer_divider) == CDM_DIV_HALF
     && !$past(stop_sec_timer, 2) && !$past(stop_sec_timer))
    |-> (sec_timer_clk_en != $past(sec_timer_clk_en)))
    else $error("secondary timer enable does not alternate at half rate");

  AST_CONV_PLL: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    ($past(converter_source_sel) == CDM_SRC_PLL && !$past(pll_tick)) |-> !converter_zero_clk_en)
    else $error("converter enable without a PLL tick");

  AST_CONV_HALF: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    ($past(converter_source_sel, 2) == CDM_SRC_SYS && $past(converter_divider, 2) == CDM_DIV_HALF
     && $past(converter_source_sel) == CDM_SRC_SYS && $past(converter_divider) == CDM_DIV_HALF
     && !$past(stop_converter_zero, 2) && !$past(stop_converter_zero))
    |-> (converter_zero_clk_en != $past(converter_zero_clk_en)))
    else $error("converter enable does not alternate at half rate");

  AST_PIN_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (standby_active && !standby_pin_float) |=> (pin_hold && !pin_float))
    else $error("pins not held in standby");

  AST_SEC_STOP: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    $past(stop_sec_timer) |-> !sec_timer_clk_en)
    else $error("secondary timer clocked while stopped");

  AST_MAIN_RUN: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    !$past(stop_main_timer) |-> (main_timer_clk_en == per_clk_en))
    else $error("primary timer clock not following peripheral clock");

  AST_OTHERS_STOP: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    ($past(stop_output_disable) |-> !output_disable_clk_en)
    and ($past(stop_i2c_module) |-> !i2c_clk_en)
    and ($past(stop_converter_zero) |-> !converter_zero_clk_en))
    else $error("stopped module still clocked");

  AST_FREQ_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    (wr_take && hit_freq && pstrb[1:0] == 2'h3) |=>
    (bus_ratio_field == $past(pwdata[10:8]) && cpu_ratio_field == $past(pwdata[6:4])
     && periph_ratio_field == $past(pwdata[2:0])))
    else $error("frequency control fields misplaced");

  AST_STBY_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    (wr_take && hit_stby && pstrb[0]) |=>
    (standby_pin_float == $past(pwdata[7]) && stop_bits == $past(pwdata[6:2])))
    else $error("standby control fields misplaced");

  AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("no answer one cycle after setup");

  // Main scenarios
  COV_SEC_PLL_HALF: cover property (@(posedge pclk) disable iff (!presetn)
    sec_timer_source_sel == CDM_SRC_PLL && sec_timer_divider == CDM_DIV_HALF && sec_timer_clk_en);
  COV_STANDBY_HOLD: cover property (@(posedge pclk) disable iff (!presetn) pin_hold);
  COV_MAIN_ONLY: cover property (@(posedge pclk) disable iff (!presetn)
    main_timer_clk_en && stop_sec_timer && stop_i2c_module);
  COV_BAD_ADDR: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);

endmodule : cdm_clock_stop_ctrl
`default_nettype wire

// *** dv/clock_divider_module_stop_tb_top.sv ***
/*
  Self-checking testbench for the clock divider and module-stop block: APB
  register access, divided clock enable rates, module clock gating and pin hold.
  Assumes the design package cdm_pkg and a 20 MHz pclk; pll_tick is modelled
  as a one-cycle pulse every fourth pclk cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module clock_divider_module_stop_tb_top import cdm_pkg::*;;
  // ==========================================================================
  // Signals and design instance
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pll_tick = 1'b0;
  logic standby_active = 1'b0;
  logic [1:0] ph = 2'h0;
  wire logic [7:0] en;
  logic pin_hold;
  logic pin_float;
  logic counting = 1'b0;
  int cnt[8];
  int mismatches = 0;
  int n_checks = 0;
  logic [3:0] pstrb = 4'hf;
  logic [3:0] strb = 4'hf;
  // Ratio and source settings with expected pulses per 64-cycle window
  logic [15:0] fq[4] = '{16'h0000, 16'h0010, 16'h0230, 16'h0101};
  int fx[4][3] = '{'{64, 64, 64}, '{64, 32, 64}, '{16, 8, 64}, '{32, 64, 32}};
  logic [7:0] sd[4] = '{8'h01, 8'h40, 8'h83, 8'h41};
  int sx[4] = '{32, 16, 8, 8};

  cdm_clock_stop_ctrl cdm_clock_stop_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pll_tick(pll_tick), .standby_active(standby_active),
    .bus_clk_en(en[0]), .cpu_clk_en(en[1]), .per_clk_en(en[2]),
    .converter_zero_clk_en(en[3]), .i2c_clk_en(en[4]), .output_disable_clk_en(en[5]),
    .main_timer_clk_en(en[6]), .sec_timer_clk_en(en[7]),
    .pin_hold(pin_hold), .pin_float(pin_float)
  );

  // ==========================================================================
  // Clock, PLL tick and enable counting
  always #25 pclk = ~pclk;

  // PLL tick every fourth cycle, so PLL-sourced rates differ from pclk rates
  always @(posedge pclk) begin
    ph <= ph + 2'h1;
    pll_tick <= (ph == 2'h0);
  end

  // Counted at the falling edge, where registered enables are settled
  always @(negedge pclk) begin
    if (counting) begin
      // An unknown enable would count as zero, so flag it here
      if ($isunknown(en)) begin
        mismatches++;
        $display("mismatch clk_en expected known seen %b", en);
      end
      for (int i = 0; i < 8; i++) cnt[i] += int'(en[i]);
    end
  end

  // ==========================================================================
  // Tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // Counts may be off by one at the window edges, never by a whole ratio
  task automatic chk_cnt(input string nm, input int ex, input int got);
    n_checks++;
    if (got < ex - 1 || got > ex + 1) begin
      mismatches++;
      $display("mismatch %s expected %0d seen %0d", nm, ex, got);
    end
  endtask : chk_cnt

  // One APB transfer; pready is sampled at rising edges, the completing edge
  // also takes read data and error, and only then is the request released
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) begin
      mismatches++;
      $display("mismatch pready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
    chk("write_err", 32'h0, {31'h0, er});
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] ex, input string nm);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(nm, ex, rd);
    chk("read_err", 32'h0, {31'h0, er});
  endtask : rd_chk

  task automatic measure();
    for (int i = 0; i < 8; i++) cnt[i] = 0;
    repeat (4) @(posedge pclk);
    counting = 1'b1;
    repeat (64) @(posedge pclk);
    counting = 1'b0;
  endtask : measure

  // ==========================================================================
  // Test sequence
  initial begin
    logic [31:0] rd;
    logic er;
    int ex;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    rd_chk(CDM_ADDR_FREQ, {16'h0, CDM_FREQ_RST}, "freq_reset");
    rd_chk(CDM_ADDR_STBY, {24'h0, CDM_STBY_RST}, "stby_reset");
    rd_chk(CDM_ADDR_SEC, {24'h0, CDM_SEC_RST}, "sec_reset");
    rd_chk(CDM_ADDR_CONV, {24'h0, CDM_CONV_RST}, "conv_reset");
    // Unmapped place: refused with error, reads zero
    apb(1'b1, 32'hfffe0000, 32'hffffffff, rd, er);
    chk("unmapped_wr_err", 32'h1, {31'h0, er});
    apb(1'b0, 32'hfffe0000, 32'h0, rd, er);
    chk("unmapped_rd_err", 32'h1, {31'h0, er});
    chk("unmapped_rd_data", 32'h0, rd);
    // Ratio fields, ending on the bus /2, cpu /1, peripheral /2 setting
    for (int f = 0; f < 4; f++) begin
      wr(CDM_ADDR_FREQ, {16'h0, fq[f]});
      rd_chk(CDM_ADDR_FREQ, {16'h0, fq[f]}, "freq_rb");
      measure();
      chk_cnt("bus_clk_en", fx[f][0], cnt[0]);
      chk_cnt("cpu_clk_en", fx[f][1], cnt[1]);
      chk_cnt("per_clk_en", fx[f][2], cnt[2]);
    end
    // Lane 1 only: bus field takes 1xx (runs undivided), lane 0 fields stay
    strb = 4'h2;
    wr(CDM_ADDR_FREQ, 32'h0777);
    strb = 4'hf;
    rd_chk(CDM_ADDR_FREQ, 32'h0701, "freq_lane");
    measure();
    chk_cnt("bus_clk_en_1xx", 64, cnt[0]);
    chk_cnt("per_clk_en_lane", 32, cnt[2]);
    wr(CDM_ADDR_FREQ, {16'h0, fq[3]});
    // Source and divider codes, all modules running, ending on PLL /2
    wr(CDM_ADDR_STBY, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(CDM_ADDR_SEC, {24'h0, sd[s]});
      wr(CDM_ADDR_CONV, {24'h0, sd[s]});
      rd_chk(CDM_ADDR_SEC, {24'h0, sd[s]}, "sec_rb");
      rd_chk(CDM_ADDR_CONV, {24'h0, sd[s]}, "conv_rb");
      measure();
      chk_cnt("sec_timer_clk_en", sx[s], cnt[3 + CDM_IDX_SEC]);
      chk_cnt("converter_zero_clk_en", sx[s], cnt[3 + CDM_IDX_CONV]);
    end
    // One stop bit at a time; only that module's clock may halt
    for (int k = 0; k < CDM_STOP_NUM; k++) begin
      wr(CDM_ADDR_STBY, 32'h1 << (CDM_STOP_LSB + k));
      measure();
      for (int j = 0; j < CDM_STOP_NUM; j++) begin
        ex = (j == CDM_IDX_SEC || j == CDM_IDX_CONV) ? 8 : 32;
        if (j == k) ex = 0;
        chk_cnt($sformatf("module_clk_en_%0d", j), ex, cnt[3 + j]);
      end
    end
    // Pin behaviour in standby with float bit clear, then set
    standby_active <= 1'b1;
    wr(CDM_ADDR_STBY, 32'h0);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("pin_hold", 32'h1, {31'h0, pin_hold});
    chk("pin_float", 32'h0, {31'h0, pin_float});
    wr(CDM_ADDR_STBY, 32'h80);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("pin_hold", 32'h0, {31'h0, pin_hold});
    chk("pin_float", 32'h1, {31'h0, pin_float});
    standby_active <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("pin_hold_run", 32'h0, {31'h0, pin_hold});
    chk("pin_float_run", 32'h0, {31'h0, pin_float});
    summarize();
  end

  // Watchdog far beyond the roughly 1100 cycles the sequence needs
  initial begin
    #(50 * 20000);
    mismatches++;
    summarize();
  end
endmodule : clock_divider_module_stop_tb_top
`default_nettype wire
